// ---- oxa_pkg.sv ----
// Shared constants, types and register map of the opcode decoder
package oxa_pkg;

	// ==========================================================
	// Register map (byte addresses, one aligned word each)
	localparam logic [3:0] REG_CTRL   = 4'h0; // Enable and flush
	localparam logic [3:0] REG_STATUS = 4'h4; // Busy, unknown, count
	localparam logic [3:0] REG_RES0   = 4'h8; // Class, fields, bytes
	localparam logic [3:0] REG_RES1   = 4'hC; // Displacement, immediate

	// ==========================================================
	// Field positions and reset values
	localparam int CTRL_EN_BIT    = 0;  // Decoder accepts bytes
	localparam int CTRL_FLUSH_BIT = 1;  // Abandon partial decode
	localparam int STAT_BUSY_BIT  = 0;  // Decode in progress
	localparam int STAT_UNK_BIT   = 1;  // Sticky unknown opcode
	localparam int STAT_CNT_LSB   = 16; // Decoded count field
	localparam logic CTRL_EN_RST  = 1'b0; // Disabled after reset

	// ==========================================================
	// Opcode bytes of this group
	localparam logic [7:0] OP_SEG_LOAD  = 8'h8E;
	localparam logic [7:0] OP_SEG_STORE = 8'h8C;
	localparam logic [7:0] OP_LOAD_EA   = 8'h8D;
	localparam logic [7:0] OP_FAR_DS    = 8'hC5;
	localparam logic [7:0] OP_FAR_ES    = 8'hC4;
	localparam logic [7:0] OP_FLAGS_AH  = 8'h9F;
	localparam logic [7:0] OP_AH_FLAGS  = 8'h9E;
	localparam logic [7:0] OP_TABLE     = 8'hD7;
	localparam logic [7:0] OP_ASC_ADD   = 8'h37;
	localparam logic [7:0] OP_DEC_ADD   = 8'h27;
	localparam logic [7:0] OP_ASC_SUB   = 8'h3F;
	localparam logic [7:0] OP_DEC_SUB   = 8'h2F;
	localparam logic [7:0] OP_ASC_MUL   = 8'hD4;
	localparam logic [7:0] OP_ASC_DIV   = 8'hD5;
	localparam logic [7:0] OP_ADJ_TAIL  = 8'h0A; // Second adjust byte
	localparam logic [7:0] OP_BYTE_SX   = 8'h98;
	localparam logic [7:0] OP_WORD_SX   = 8'h99;
	localparam logic [5:0] PFX_IMM_GRP  = 6'b100000; // 100000sw
	localparam logic [5:0] PFX_ADC_RM   = 6'b000100; // 000100dw
	localparam logic [5:0] PFX_SBB_RM   = 6'b000110; // 000110dw
	localparam logic [6:0] PFX_UNARY    = 7'b1111011; // 1111011w
	localparam logic [1:0] SW_TWO_IMM   = 2'b01; // Two immediate bytes

	// ==========================================================
	// Instruction classes and operations
	typedef enum logic [4:0] {
		CL_NONE, CL_SEG_LOAD, CL_SEG_STORE, CL_LOAD_EA, CL_FAR_DS,
		CL_FAR_ES, CL_FLAGS_AH, CL_AH_FLAGS, CL_TABLE, CL_IMM_GRP,
		CL_ADC_RM, CL_SBB_RM, CL_ASC_ADD, CL_DEC_ADD, CL_ASC_SUB,
		CL_DEC_SUB, CL_ASC_MUL, CL_ASC_DIV, CL_UNARY, CL_BYTE_SX,
		CL_WORD_SX, CL_UNKNOWN
	} oxa_cls_t;

	typedef enum logic [3:0] {
		OPN_NONE, OPN_ADD, OPN_ADC, OPN_SBB, OPN_SUB, OPN_CMP,
		OPN_NEG, OPN_UMUL, OPN_SMUL, OPN_UDIV, OPN_SDIV
	} oxa_opn_t;

	// Decoded instruction, packed as the two result words
	typedef struct packed {
		logic [15:0] disp;     // Sign-extended displacement
		logic [15:0] imm;      // Immediate, extended where asked
		oxa_cls_t    cls;      // Instruction class
		oxa_opn_t    opn;      // Arithmetic operation
		logic        wide;     // Word operation
		logic        dir;      // Register field is destination
		logic        sx;       // Immediate byte sign-extended
		logic [1:0]  disp_len; // Displacement bytes
		logic [1:0]  imm_len;  // Immediate bytes
		logic [7:0]  modrm;    // Operand form byte
		logic [7:0]  opcode;   // First byte
	} oxa_res_t;

endpackage : oxa_pkg

// ---- oxa_modrm_len.sv ----
// Displacement length from the operand form byte
`timescale 1ns/1ps

module oxa_modrm_len (
	input  wire logic [7:0] modrm_i,    // Operand form byte
	output logic      [1:0] disp_len_o, // Displacement bytes
	output logic            reg_form_o  // Operand is a register
);

	// ==========================================================
	// Form decode
	// Form 00 with locator 110 is a direct 16-bit address
	always_comb begin
		disp_len_o = 2'h0;
		reg_form_o = 1'b0;
		case (modrm_i[7:6])
			2'b00: begin // No offset, except direct address
				if (modrm_i[2:0] == 3'b110) begin
					disp_len_o = 2'h2;
				end
			end
			2'b01: disp_len_o = 2'h1; // Short signed offset
			2'b10: disp_len_o = 2'h2; // Full offset
			default: reg_form_o = 1'b1; // Register operand
		endcase
	end

endmodule : oxa_modrm_len

// ---- oxa_decoder.sv ----
// Opcode decoder for transfer and arithmetic group, Avalon-MM slave
//
// Summary of operation
// - 8E loads segment register from operand
// - 8C stores segment register to operand
// - 8D puts effective address in register
// - C5 loads far pointer with data segment
// - C4 loads far pointer with extra segment
// - 9F flags to high acc, 9E back
// - D7 is table byte lookup
// - 100000sw immediate group, field selects op
// - 000100dw is add-with-carry register form
// - 000110dw is subtract-with-borrow register form
// - 37 is ascii add adjust
// - 27 is decimal add adjust
// - 3F is ascii subtract adjust
// - 2F is decimal subtract adjust
// - D4 0A is ascii multiply adjust
// - D5 0A is ascii divide adjust
// - 1111011w unary group, field selects op
// - 98 sign-extends byte into word
// - 99 sign-extends word into double word
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps

module oxa_decoder (
	input  wire logic        clk_i,             // 40 MHz clock
	input  wire logic        rst_i,             // Async reset, high
	input  wire logic [7:0]  byte_i,            // Byte from queue
	input  wire logic        byte_valid_i,      // Byte offered
	output logic             byte_ready_o,      // Byte taken if valid
	output logic             done_o,            // Result pulse
	output oxa_pkg::oxa_res_t res_o,            // Last result
	input  wire logic [3:0]  avs_address_i,     // Byte address
	input  wire logic        avs_read_i,        // Read request
	input  wire logic        avs_write_i,       // Write request
	input  wire logic [31:0] avs_writedata_i,   // Write data
	input  wire logic [3:0]  avs_byteenable_i,  // Byte lanes
	output logic [31:0]      avs_readdata_o,    // Read data
	output logic             avs_waitrequest_o  // Stall
);

	// ==========================================================
	// Helper functions
	// First-byte class lookup; groups resolved later by modrm
	function automatic oxa_pkg::oxa_cls_t cls_of(input logic [7:0] b);
		oxa_pkg::oxa_cls_t c;
		c = oxa_pkg::CL_UNKNOWN;
		case (b)
			oxa_pkg::OP_SEG_LOAD:  c = oxa_pkg::CL_SEG_LOAD;
			oxa_pkg::OP_SEG_STORE: c = oxa_pkg::CL_SEG_STORE;
			oxa_pkg::OP_LOAD_EA:   c = oxa_pkg::CL_LOAD_EA;
			oxa_pkg::OP_FAR_DS:    c = oxa_pkg::CL_FAR_DS;
			oxa_pkg::OP_FAR_ES:    c = oxa_pkg::CL_FAR_ES;
			oxa_pkg::OP_FLAGS_AH:  c = oxa_pkg::CL_FLAGS_AH;
			oxa_pkg::OP_AH_FLAGS:  c = oxa_pkg::CL_AH_FLAGS;
			oxa_pkg::OP_TABLE:     c = oxa_pkg::CL_TABLE;
			oxa_pkg::OP_ASC_ADD:   c = oxa_pkg::CL_ASC_ADD;
			oxa_pkg::OP_DEC_ADD:   c = oxa_pkg::CL_DEC_ADD;
			oxa_pkg::OP_ASC_SUB:   c = oxa_pkg::CL_ASC_SUB;
			oxa_pkg::OP_DEC_SUB:   c = oxa_pkg::CL_DEC_SUB;
			oxa_pkg::OP_ASC_MUL:   c = oxa_pkg::CL_ASC_MUL;
			oxa_pkg::OP_ASC_DIV:   c = oxa_pkg::CL_ASC_DIV;
			oxa_pkg::OP_BYTE_SX:   c = oxa_pkg::CL_BYTE_SX;
			oxa_pkg::OP_WORD_SX:   c = oxa_pkg::CL_WORD_SX;
			default: begin
				if (b[7:2] == oxa_pkg::PFX_IMM_GRP) begin
					c = oxa_pkg::CL_IMM_GRP;
				end else if (b[7:2] == oxa_pkg::PFX_ADC_RM) begin
					c = oxa_pkg::CL_ADC_RM;
				end else if (b[7:2] == oxa_pkg::PFX_SBB_RM) begin
					c = oxa_pkg::CL_SBB_RM;
				end else if (b[7:1] == oxa_pkg::PFX_UNARY) begin
					c = oxa_pkg::CL_UNARY;
				end
			end
		endcase
		return c;
	endfunction : cls_of

	// Classes whose second byte is an operand form byte
	function automatic logic has_modrm(input oxa_pkg::oxa_cls_t c);
		return (c == oxa_pkg::CL_SEG_LOAD) || (c == oxa_pkg::CL_SEG_STORE) ||
			(c == oxa_pkg::CL_LOAD_EA) || (c == oxa_pkg::CL_FAR_DS) ||
			(c == oxa_pkg::CL_FAR_ES) || (c == oxa_pkg::CL_IMM_GRP) ||
			(c == oxa_pkg::CL_ADC_RM) || (c == oxa_pkg::CL_SBB_RM) ||
			(c == oxa_pkg::CL_UNARY);
	endfunction : has_modrm

	// Signed byte widened to a word
	function automatic logic [15:0] sext8(input logic [7:0] b);
		return {{8{b[7]}}, b};
	endfunction : sext8

	// ==========================================================
	// Declarations
	typedef enum {ST_OPCODE, ST_MODRM, ST_ADJ, ST_DISP, ST_IMM} oxa_st_t;

	oxa_st_t           st_q, st_d;       // Decode state
	oxa_pkg::oxa_res_t wk_q, wk_d;       // Result under construction
	oxa_pkg::oxa_res_t res_q, res_d;     // Published result
	logic [1:0]        cnt_q, cnt_d;     // Bytes gathered in a field
	logic              done_q, done_d;   // Completion pulse
	logic              rdy_q, rdy_d;     // Ready to the queue
	logic              en_q, en_d;       // Software enable
	logic              unk_q, unk_d;     // Sticky unknown opcode
	logic [15:0]       num_q, num_d;     // Decoded instruction count
	logic              wait_q, wait_d;   // Bus stall
	logic [31:0]       rdat_q, rdat_d;   // Bus read data
	logic              take;             // Byte accepted this cycle
	logic              flush;            // Software abandons decode
	logic              wr_go;            // Write takes effect
	logic [1:0]        ml_disp;          // Offset bytes of this byte
	logic              ml_reg;           // Register form of this byte

	assign take  = byte_valid_i && rdy_q;
	assign wr_go = avs_write_i && !wait_q;
	assign flush = wr_go && (avs_address_i == oxa_pkg::REG_CTRL) &&
		avs_byteenable_i[0] && avs_writedata_i[oxa_pkg::CTRL_FLUSH_BIT];

	// Offset length of the byte on the input, used as the form byte
	oxa_modrm_len u_len (
		.modrm_i    (byte_i),
		.disp_len_o (ml_disp),
		.reg_form_o (ml_reg)
	);

	// ==========================================================
	// Decode sequencer, next values
	// Finishing updates the published result in the same step
	always_comb begin
		logic fin;
		fin    = 1'b0;
		st_d   = st_q;
		wk_d   = wk_q;
		cnt_d  = cnt_q;
		res_d  = res_q;
		if (flush) begin // Flush beats any byte in flight
			st_d  = ST_OPCODE;
			cnt_d = 2'h0;
		end else if (take) begin
			case (st_q)
				ST_OPCODE: begin
					wk_d        = '0;
					wk_d.opcode = byte_i;
					wk_d.cls    = cls_of(byte_i);
					wk_d.wide   = byte_i[0];
					if (wk_d.cls == oxa_pkg::CL_ADC_RM) begin
						wk_d.opn = oxa_pkg::OPN_ADC;
						wk_d.dir = byte_i[1];
					end
					if (wk_d.cls == oxa_pkg::CL_SBB_RM) begin
						wk_d.opn = oxa_pkg::OPN_SBB;
						wk_d.dir = byte_i[1];
					end
					if (wk_d.cls == oxa_pkg::CL_IMM_GRP) begin
						wk_d.sx = byte_i[1] && byte_i[0];
					end
					if ((wk_d.cls == oxa_pkg::CL_ASC_MUL) ||
						(wk_d.cls == oxa_pkg::CL_ASC_DIV)) begin
						st_d = ST_ADJ;
					end else if (has_modrm(wk_d.cls)) begin
						st_d = ST_MODRM;
					end else begin
						fin = 1'b1; // Single-byte forms
					end
				end
				ST_MODRM: begin
					wk_d.modrm    = byte_i;
					wk_d.disp_len = ml_disp;
					case (wk_q.cls)
						oxa_pkg::CL_IMM_GRP: begin
							wk_d.imm_len = (wk_q.opcode[1:0] ==
								oxa_pkg::SW_TWO_IMM) ? 2'h2 : 2'h1;
							case (byte_i[5:3])
								3'b000: wk_d.opn = oxa_pkg::OPN_ADD;
								3'b010: wk_d.opn = oxa_pkg::OPN_ADC;
								3'b011: wk_d.opn = oxa_pkg::OPN_SBB;
								3'b101: wk_d.opn = oxa_pkg::OPN_SUB;
								3'b111: wk_d.opn = oxa_pkg::OPN_CMP;
								default: wk_d.cls = oxa_pkg::CL_UNKNOWN;
							endcase
						end
						oxa_pkg::CL_UNARY: begin
							case (byte_i[5:3])
								3'b011: wk_d.opn = oxa_pkg::OPN_NEG;
								3'b100: wk_d.opn = oxa_pkg::OPN_UMUL;
								3'b101: wk_d.opn = oxa_pkg::OPN_SMUL;
								3'b110: wk_d.opn = oxa_pkg::OPN_UDIV;
								3'b111: wk_d.opn = oxa_pkg::OPN_SDIV;
								default: wk_d.cls = oxa_pkg::CL_UNKNOWN;
							endcase
						end
						oxa_pkg::CL_SEG_LOAD,
						oxa_pkg::CL_SEG_STORE: begin
							if (byte_i[5]) begin // Zero bit must be clear
								wk_d.cls = oxa_pkg::CL_UNKNOWN;
							end
						end
						default: ; // Form byte carries operands only
					endcase
					// Offset bytes come before immediate bytes
					if (ml_disp != 2'h0) begin
						st_d = ST_DISP;
					end else if (wk_d.imm_len != 2'h0) begin
						st_d = ST_IMM;
					end else begin
						fin = 1'b1;
					end
					cnt_d = 2'h0;
				end
				ST_ADJ: begin
					wk_d.modrm = byte_i;
					if (byte_i != oxa_pkg::OP_ADJ_TAIL) begin
						wk_d.cls = oxa_pkg::CL_UNKNOWN;
					end
					fin = 1'b1;
				end
				ST_DISP: begin
					if (cnt_q == 2'h0) begin
						wk_d.disp = sext8(byte_i); // Short offset signed
					end else begin
						wk_d.disp[15:8] = byte_i;
					end
					cnt_d = cnt_q + 2'h1;
					if (cnt_d == wk_q.disp_len) begin
						cnt_d = 2'h0;
						if (wk_q.imm_len != 2'h0) begin
							st_d = ST_IMM;
						end else begin
							fin = 1'b1;
						end
					end
				end
				ST_IMM: begin
					if (cnt_q == 2'h0) begin
						wk_d.imm = {8'h00, byte_i};
						if (wk_q.sx) begin
							wk_d.imm = sext8(byte_i);
						end
					end else begin
						wk_d.imm[15:8] = byte_i;
					end
					cnt_d = cnt_q + 2'h1;
					if (cnt_d == wk_q.imm_len) begin
						cnt_d = 2'h0;
						fin   = 1'b1;
					end
				end
				default: st_d = ST_OPCODE;
			endcase
		end
		if (fin) begin
			st_d  = ST_OPCODE;
			res_d = wk_d;
		end
		done_d = fin;
		rdy_d  = en_d; // Queue stalls while disabled
	end

	// Decode sequencer registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_q   <= ST_OPCODE;
			wk_q   <= '0;
			res_q  <= '0;
			cnt_q  <= 2'h0;
			done_q <= 1'b0;
			rdy_q  <= 1'b0;
		end else begin
			st_q   <= st_d;
			wk_q   <= wk_d;
			res_q  <= res_d;
			cnt_q  <= cnt_d;
			done_q <= done_d;
			rdy_q  <= rdy_d;
		end
	end

	// ==========================================================
	// Register slave, next values
	// One stall cycle per access; read data captured while stalled
	always_comb begin
		en_d   = en_q;
		unk_d  = unk_q;
		num_d  = num_q;
		rdat_d = rdat_q;
		wait_d = !((avs_read_i || avs_write_i) && wait_q);
		if (wr_go && (avs_address_i == oxa_pkg::REG_CTRL) &&
			avs_byteenable_i[0]) begin
			en_d = avs_writedata_i[oxa_pkg::CTRL_EN_BIT];
		end
		// Write-one clears; a new unknown opcode wins over the clear
		if (wr_go && (avs_address_i == oxa_pkg::REG_STATUS) &&
			avs_byteenable_i[0] &&
			avs_writedata_i[oxa_pkg::STAT_UNK_BIT]) begin
			unk_d = 1'b0;
		end
		if (done_d && (res_d.cls == oxa_pkg::CL_UNKNOWN)) begin
			unk_d = 1'b1;
		end
		if (done_d) begin
			num_d = num_q + 16'h0001; // Wraps silently
		end
		if (avs_read_i && wait_q) begin
			case (avs_address_i)
				oxa_pkg::REG_CTRL: begin
					rdat_d = 32'h0000_0000;
					rdat_d[oxa_pkg::CTRL_EN_BIT] = en_q;
				end
				oxa_pkg::REG_STATUS: begin
					rdat_d = 32'h0000_0000;
					rdat_d[oxa_pkg::STAT_BUSY_BIT] = (st_q != ST_OPCODE);
					rdat_d[oxa_pkg::STAT_UNK_BIT]  = unk_q;
					rdat_d[oxa_pkg::STAT_CNT_LSB +: 16] = num_q;
				end
				oxa_pkg::REG_RES0: rdat_d = res_q[31:0];
				oxa_pkg::REG_RES1: rdat_d = res_q[63:32];
				default: rdat_d = 32'h0000_0000; // Unmapped reads zero
			endcase
		end
	end

	// Register slave registers
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_q   <= oxa_pkg::CTRL_EN_RST;
			unk_q  <= 1'b0;
			num_q  <= 16'h0000;
			wait_q <= 1'b1;
			rdat_q <= 32'h0000_0000;
		end else begin
			en_q   <= en_d;
			unk_q  <= unk_d;
			num_q  <= num_d;
			wait_q <= wait_d;
			rdat_q <= rdat_d;
		end
	end

	assign byte_ready_o      = rdy_q;
	assign done_o            = done_q;
	assign res_o             = res_q;
	assign avs_readdata_o    = rdat_q;
	assign avs_waitrequest_o = wait_q;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_adj_tail;
		take && (st_q == ST_ADJ) && (byte_i == oxa_pkg::OP_ADJ_TAIL);
	endsequence

	sequence s_modrm_seg;
		take && !flush && (st_q == ST_MODRM) && !byte_i[5] &&
			(wk_q.opcode == oxa_pkg::OP_SEG_LOAD);
	endsequence

	seg_load_class_a: assert property (
		s_modrm_seg ##0 (ml_disp == 2'h0) |=> done_o &&
			(res_o.cls == oxa_pkg::CL_SEG_LOAD))
		else $error("segment load not decoded");

	lea_class_a: assert property (
		done_o && (res_o.opcode == oxa_pkg::OP_LOAD_EA) |->
			(res_o.cls == oxa_pkg::CL_LOAD_EA))
		else $error("effective address load misdecoded");

	flag_xfer_a: assert property (
		take && (st_q == ST_OPCODE) && !flush &&
			(byte_i == oxa_pkg::OP_FLAGS_AH) |=> done_o &&
			(res_o.cls == oxa_pkg::CL_FLAGS_AH) && (st_q == ST_OPCODE))
		else $error("flags transfer not single byte");

	adj_mul_a: assert property (
		s_adj_tail ##0 (wk_q.opcode == oxa_pkg::OP_ASC_MUL) && !flush
			|=> done_o && (res_o.cls == oxa_pkg::CL_ASC_MUL))
		else $error("multiply adjust misdecoded");

	imm_len_a: assert property (
		done_o && (res_o.cls == oxa_pkg::CL_IMM_GRP) |->
			(res_o.imm_len == ((res_o.opcode[1:0] == 2'b01) ? 2'h2 : 2'h1)))
		else $error("immediate length wrong");

	imm_sext_a: assert property (
		done_o && (res_o.cls == oxa_pkg::CL_IMM_GRP) &&
			(res_o.opcode[1:0] == 2'b11) |->
			(res_o.imm[15:8] == {8{res_o.imm[7]}}) && res_o.sx)
		else $error("immediate not sign-extended");

	dir_width_a: assert property (
		done_o && (res_o.cls == oxa_pkg::CL_SBB_RM) |->
			(res_o.wide == res_o.opcode[0]) &&
			(res_o.dir == res_o.opcode[1]) &&
			(res_o.opn == oxa_pkg::OPN_SBB))
		else $error("width or direction wrong");

	direct_disp_a: assert property (
		done_o && (res_o.modrm[7:6] == 2'b00) && has_modrm(res_o.cls) &&
			(res_o.modrm[2:0] == 3'b110) |-> (res_o.disp_len == 2'h2))
		else $error("direct address offset length wrong");

	unary_mul_a: assert property (
		done_o && (res_o.cls == oxa_pkg::CL_UNARY) &&
			(res_o.modrm[5:3] == 3'b101) |-> (res_o.opn == oxa_pkg::OPN_SMUL))
		else $error("signed product misdecoded");

	bus_stall_a: assert property (
		(avs_read_i || avs_write_i) && avs_waitrequest_o |=>
			!avs_waitrequest_o ##1 avs_waitrequest_o)
		else $error("bus answer not after one stall");

endmodule : oxa_decoder

// ---- oxa_queue_model.sv ----
// Behavioural prefetch queue that feeds opcode bytes to the decoder
`timescale 1ns/1ps

module oxa_queue_model (
	input  wire logic       clk_i,   // Decoder clock
	input  wire logic       rst_i,   // Async reset, high
	input  wire logic       ready_i, // Decoder takes byte
	output logic      [7:0] byte_o,  // Offered byte
	output logic            valid_o  // Byte offered
);
	// ==========================================================
	// Pending bytes, filled by the bench
	logic [7:0] fifo_q[$]; // Bytes not yet taken

	// Bench appends one byte to the stream
	task automatic push(input logic [7:0] b);
		fifo_q.push_back(b);
	endtask : push

	// ==========================================================
	// Offer logic: random gaps, hold until taken
	always @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			byte_o  <= 8'h00;
		end else begin
			// Byte leaves only at the accepting edge
			if (valid_o && ready_i)
				void'(fifo_q.pop_front());
			if (!valid_o || ready_i) begin
				if (fifo_q.size() > 0 && $urandom_range(3) != 0) begin
					valid_o <= 1'b1;
					byte_o  <= fifo_q[0];
				end else begin
					// Idle bus toggles so stale data never looks valid
					valid_o <= 1'b0;
					byte_o  <= ~byte_o;
				end
			end
		end
	end
endmodule : oxa_queue_model

// ---- test_opcode_decoder_xfer_arith.sv ----
// Self-checking bench for the transfer and arithmetic opcode decoder
`timescale 1ns/1ps

module test_opcode_decoder_xfer_arith;
	// ==========================================================
	// Signals
	logic              clk_i, rst_i;      // Clock and reset
	logic        [7:0] byte_w;            // Stream byte
	logic              valid_w, ready_w;  // Stream handshake
	logic              done_w;            // Result pulse
	oxa_pkg::oxa_res_t res_w;             // Result
	logic        [3:0] av_addr;           // Bus address
	logic              av_rd, av_wr;      // Bus requests
	logic       [31:0] av_wd, av_rdata;   // Bus data
	logic              av_wait;           // Bus stall
	logic       [31:0] rd;                // Read-back value
	logic        [7:0] fb;                // Random form byte
	oxa_pkg::oxa_res_t exp_q[$], last_e;  // Expected results
	int                error_cnt, checks_done, ncnt, cyc_cnt;
	logic        [7:0] sgl[9] = '{8'h9F, 8'h9E, 8'hD7, 8'h37, 8'h27,
		8'h3F, 8'h2F, 8'h98, 8'h99};   // One-byte opcodes
	oxa_pkg::oxa_cls_t scl[9] = '{oxa_pkg::CL_FLAGS_AH,
		oxa_pkg::CL_AH_FLAGS, oxa_pkg::CL_TABLE, oxa_pkg::CL_ASC_ADD,
		oxa_pkg::CL_DEC_ADD, oxa_pkg::CL_ASC_SUB, oxa_pkg::CL_DEC_SUB,
		oxa_pkg::CL_BYTE_SX, oxa_pkg::CL_WORD_SX}; // Their classes

	// ==========================================================
	// Design and queue model
	oxa_decoder dut_u (.clk_i(clk_i), .rst_i(rst_i), .byte_i(byte_w),
		.byte_valid_i(valid_w), .byte_ready_o(ready_w), .done_o(done_w),
		.res_o(res_w), .avs_address_i(av_addr), .avs_read_i(av_rd),
		.avs_write_i(av_wr), .avs_writedata_i(av_wd),
		.avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata),
		.avs_waitrequest_o(av_wait));
	oxa_queue_model q_u (.clk_i(clk_i), .rst_i(rst_i), .ready_i(ready_w),
		.byte_o(byte_w), .valid_o(valid_w));

	// ==========================================================
	// Tasks
	task automatic conclude();
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : conclude

	task automatic cmp(input logic [63:0] g, e, input string m);
		checks_done++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, g, e);
		end
	endtask : cmp

	// Avalon access: hold until waitrequest is seen low at an edge
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] r);
		av_addr <= a;
		av_wd   <= d;
		av_wr   <= w;
		av_rd   <= !w;
		do @(posedge clk_i); while (av_wait !== 1'b0);
		r = av_rdata;
		av_rd <= 1'b0;
		av_wr <= 1'b0;
		@(posedge clk_i); // Idle edge so a next call never re-raises at once
	endtask : bus

	// Send one instruction; k: 0 single, 1 fixed tail, 2 form byte
	task automatic ins(input logic [7:0] op, f, input int k,
		input oxa_pkg::oxa_cls_t c, input oxa_pkg::oxa_opn_t o);
		oxa_pkg::oxa_res_t e;
		logic [7:0] b[4];
		int dl, il;
		e = '0;
		dl = 0;
		il = 0;
		foreach (b[i]) b[i] = 8'($urandom);
		if (k == 2)
			dl = (f[7:6] == 2'b00) ? ((f[2:0] == 3'b110) ? 2 : 0) :
				(f[7:6] == 2'b01) ? 1 : (f[7:6] == 2'b10) ? 2 : 0;
		// Immediate bytes follow even when the field is refused
		if (op[7:2] == oxa_pkg::PFX_IMM_GRP)
			il = (op[1:0] == oxa_pkg::SW_TWO_IMM) ? 2 : 1;
		e.opcode = op;
		e.modrm = (k != 0) ? f : 8'h00;
		e.cls = c;
		e.opn = o;
		e.wide = op[0];
		e.dir = (c == oxa_pkg::CL_ADC_RM || c == oxa_pkg::CL_SBB_RM) & op[1];
		e.sx = (op[7:2] == oxa_pkg::PFX_IMM_GRP) && (op[1:0] == 2'b11);
		e.disp_len = 2'(dl);
		e.imm_len = 2'(il);
		e.disp = (dl == 1) ? {{8{b[0][7]}}, b[0]} :
			(dl == 2) ? {b[1], b[0]} : 16'h0000;
		e.imm = (il == 2) ? {b[dl+1], b[dl]} : (il == 0) ? 16'h0000 :
			e.sx ? {{8{b[dl][7]}}, b[dl]} : {8'h00, b[dl]};
		exp_q.push_back(e);
		last_e = e;
		ncnt++;
		q_u.push(op);
		if (k != 0)
			q_u.push(f);
		for (int i = 0; i < dl + il; i++)
			q_u.push(b[i]);
	endtask : ins

	// ==========================================================
	// Clock, timeout and result monitor
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	always @(posedge clk_i) begin
		cyc_cnt++;
		if (cyc_cnt == 30000) begin
			error_cnt++;
			conclude();
		end
	end

	// Oldest note is matched against each done pulse
	always @(posedge clk_i) begin
		if (rst_i === 1'b0 && done_w === 1'b1) begin
			if (exp_q.size() == 0)
				cmp(64'h1, 64'h0, "unexpected done");
			else
				cmp(res_w, exp_q.pop_front(), "result");
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(87));
		rst_i = 1'b1;
		av_addr = 4'h0;
		av_rd = 1'b0;
		av_wr = 1'b0;
		av_wd = 32'h0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b0, oxa_pkg::REG_CTRL, 32'h0, rd);
		cmp({32'h0, rd}, 64'h0, "ctrl reset");
		cmp({63'h0, ready_w}, 64'h0, "ready while disabled");
		bus(1'b0, 4'h2, 32'h0, rd);
		cmp({32'h0, rd}, 64'h0, "unmapped read");
		bus(1'b1, oxa_pkg::REG_CTRL, 32'h1, rd);
		foreach (sgl[i]) ins(sgl[i], 8'h00, 0, scl[i], oxa_pkg::OPN_NONE);
		ins(8'hD4, 8'h0A, 1, oxa_pkg::CL_ASC_MUL, oxa_pkg::OPN_NONE);
		ins(8'hD5, 8'h0A, 1, oxa_pkg::CL_ASC_DIV, oxa_pkg::OPN_NONE);
		ins(8'hD4, 8'h0B, 1, oxa_pkg::CL_UNKNOWN, oxa_pkg::OPN_NONE);
		ins(8'hF0, 8'h00, 0, oxa_pkg::CL_UNKNOWN, oxa_pkg::OPN_NONE);
		for (int s = 0; s < 4; s++) begin
			fb = 8'($urandom) & 8'hDF;
			ins(8'h8E, fb, 2, oxa_pkg::CL_SEG_LOAD, oxa_pkg::OPN_NONE);
			ins(8'h8E, fb | 8'h20, 2, oxa_pkg::CL_UNKNOWN, oxa_pkg::OPN_NONE);
			ins(8'h8C, fb, 2, oxa_pkg::CL_SEG_STORE, oxa_pkg::OPN_NONE);
			ins(8'h8D, fb, 2, oxa_pkg::CL_LOAD_EA, oxa_pkg::OPN_NONE);
			ins(8'hC5, fb, 2, oxa_pkg::CL_FAR_DS, oxa_pkg::OPN_NONE);
			ins(8'hC4, fb, 2, oxa_pkg::CL_FAR_ES, oxa_pkg::OPN_NONE);
			ins({6'b000100, 2'(s)}, 8'($urandom), 2, oxa_pkg::CL_ADC_RM, oxa_pkg::OPN_ADC);
			ins({6'b000110, 2'(s)}, 8'($urandom), 2, oxa_pkg::CL_SBB_RM, oxa_pkg::OPN_SBB);
			for (int f = 0; f < 8; f++) begin
				fb = 8'($urandom);
				fb[5:3] = 3'(f);
				// Refused fields complete as unknown
				ins({6'b100000, 2'(s)}, fb, 2, (f == 1 || f == 4 || f == 6) ?
					oxa_pkg::CL_UNKNOWN : oxa_pkg::CL_IMM_GRP,
					(f == 0) ? oxa_pkg::OPN_ADD : (f == 2) ? oxa_pkg::OPN_ADC :
					(f == 3) ? oxa_pkg::OPN_SBB : (f == 5) ? oxa_pkg::OPN_SUB :
					(f == 7) ? oxa_pkg::OPN_CMP : oxa_pkg::OPN_NONE);
				ins({7'b1111011, s[0]}, fb, 2, (f < 3) ? oxa_pkg::CL_UNKNOWN :
					oxa_pkg::CL_UNARY, (f < 3) ? oxa_pkg::OPN_NONE :
					oxa_pkg::oxa_opn_t'(f + 3));
			end
		end
		for (int i = 0; i < 5000 && exp_q.size() > 0; i++) @(posedge clk_i);
		cmp(64'(exp_q.size()), 64'h0, "results missing");
		bus(1'b0, oxa_pkg::REG_STATUS, 32'h0, rd);
		cmp({48'h0, rd[31:16]}, 64'(ncnt), "done count");
		cmp({62'h0, rd[1:0]}, 64'h2, "unknown sticky, idle");
		bus(1'b0, oxa_pkg::REG_RES0, 32'h0, rd);
		cmp({32'h0, rd}, {32'h0, last_e[31:0]}, "res0 word");
		bus(1'b1, oxa_pkg::REG_STATUS, 32'h2, rd); // Clear sticky unknown
		q_u.push(8'h8E); // Opcode whose form byte never comes
		repeat (20) @(posedge clk_i);
		bus(1'b0, oxa_pkg::REG_STATUS, 32'h0, rd);
		cmp({62'h0, rd[1:0]}, 64'h1, "cleared, busy");
		bus(1'b1, oxa_pkg::REG_CTRL, 32'h3, rd); // Flush, stay enabled
		ins(8'h98, 8'h00, 0, oxa_pkg::CL_BYTE_SX, oxa_pkg::OPN_NONE);
		for (int i = 0; i < 5000 && exp_q.size() > 0; i++) @(posedge clk_i);
		cmp(64'(exp_q.size()), 64'h0, "result after flush missing");
		conclude();
	end
endmodule : test_opcode_decoder_xfer_arith
